/* inc/acc_map.svh */
// Register map, field positions and timing counts of the converter control
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACC_OFF_CCS     8'h00
`define ACC_OFF_DID     8'h04
`define ACC_OFF_CTLA    8'h08
`define ACC_OFF_CTLB    8'h0c
`define ACC_OFF_INSEL   8'h10
`define ACC_OFF_RESLO   8'h14
`define ACC_OFF_RESHI   8'h18
`define ACC_OFF_PINS    8'h1c
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACC_CCS_OFF     7
`define ACC_CCS_BG      6
`define ACC_CCS_FLAG    4
`define ACC_CCS_IE      3
`define ACC_CTLA_EN     7
`define ACC_CTLA_SC     6
`define ACC_CTLA_ATE    5
`define ACC_CTLA_FLAG   4
`define ACC_CTLA_IE     3
`define ACC_CTLB_ME     6
`define ACC_INSEL_LAR   5
// ----------------------------------------------------------------------
// Encodings, reset values and counts
// ----------------------------------------------------------------------
`define ACC_EVT_TOGGLE  2'h0
`define ACC_EVT_FALL    2'h2
`define ACC_EVT_RISE    2'h3
`define ACC_TRIG_DONE   3'h0
`define ACC_RST_BYTE    8'h00
`define ACC_RST_DID     6'h00
`define ACC_PRESC_DIV   8'h04
`define ACC_TICKS_NORM  5'h0d
`define ACC_TICKS_FIRST 5'h19
`endif

/* inc/acc_pkg.sv */
// Types shared by the converter and comparator control block
package acc_pkg;
   // Conversion engine states, one-hot
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b01,
      ACC_RUN  = 2'b10
   } acc_conv_e;

   // Whole state of the block
   typedef struct packed {
      logic [31:0] rdata;      // Bus read data
      logic        ready;      // Bus ready
      logic        err;        // Bus error
      logic        cmp_off;    // Comparator power off
      logic        bg_sel;     // Bandgap select
      logic        cmp_flag;   // Comparator event flag
      logic        cmp_ie;     // Comparator interrupt enable
      logic [1:0]  evt_sel;    // Event select
      logic [5:0]  did;        // Digital input disables
      logic        ena;        // Converter enable
      logic        start;      // Start / in progress
      logic        ate;        // Auto trigger enable
      logic        done_flag;  // Conversion done flag
      logic        done_ie;    // Done interrupt enable
      logic [2:0]  presc_sel;  // Prescaler select, stored only
      logic        mux_en;     // Comparator mux enable
      logic [2:0]  trig_sel;   // Trigger source select
      logic [7:0]  insel;      // Input select register
      logic [9:0]  result;     // Last stored result
      logic        lock;       // Data registers locked
      acc_conv_e   conv;       // Engine state
      logic        first;      // Next conversion is the long one
      logic [7:0]  presc;      // Prescaler count
      logic [4:0]  ticks;      // Converter ticks in conversion
      logic        trig_prev;  // Previous trigger level
      logic        cmp_s1;     // Comparator sync stage 1
      logic        cmp_s2;     // Comparator sync stage 2
      logic        cmp_prev;   // Previous synchronised sample
      logic [1:0]  pin_s1;     // Pin sync stage 1
      logic [1:0]  pin_s2;     // Pin sync stage 2
      logic [1:0]  pin_val;    // Masked pin value
      logic        neg_mux;    // Comparator negative from mux
      logic [1:0]  chan;       // Applied channel
      logic [1:0]  refsel;     // Applied reference
      logic        cmp_irq;    // Comparator interrupt request
      logic        conv_irq;   // Converter interrupt request
   } acc_state_s;
endpackage : acc_pkg

/* design/acc_ctrl.sv */
// Converter and comparator control with an APB register slave
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_ctrl (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // CPU interrupt side
   input  wire logic        gie_in,
   input  wire logic        cmp_vector_ack_in,
   input  wire logic        conv_vector_ack_in,
   output logic             cmp_irq_out,
   output logic             conv_irq_out,
   // Auto trigger sources from other peripherals
   input  wire logic [5:0]  trigger_in,
   // Analog comparator
   input  wire logic        cmp_raw_in,
   output logic             cmp_power_off_out,
   output logic             cmp_bandgap_sel_out,
   output logic             cmp_neg_from_mux_out,
   output logic      [1:0]  cmp_mux_channel_out,
   // Converter core
   input  wire logic [9:0]  conv_result_in,
   output logic             conv_power_out,
   output logic             conv_busy_out,
   output logic             conv_first_out,
   output logic      [1:0]  conv_channel_out,
   output logic      [1:0]  conv_reference_out,
   // Comparator pins
   input  wire logic [1:0]  pin_raw_in,
   output logic      [1:0]  pin_buffer_off_out,
   output logic      [1:0]  pin_value_out
);
   import acc_pkg::*;

   acc_state_s s_reg;   // Registered state
   acc_state_s s_next;  // Next state

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   // All behaviour lives in this one process
   always_comb begin
      logic       acc_wr;     // Write taken this edge
      logic       acc_rd;     // Read taken this edge
      logic [7:0] wd;         // Write data byte
      logic [7:0] rb;         // Read data byte
      logic       cmp_evt;    // Comparator event seen
      logic       cmp_clr;    // Comparator flag clear
      logic       done_set;   // Conversion completed
      logic       done_clr;   // Done flag clear
      logic       tick;       // Converter clock tick
      logic       trig_lvl;   // Selected trigger level
      logic       trig_edge;  // Rising trigger edge
      logic       free_run;   // Done flag is trigger source
      logic [7:0] trig_vec;   // All trigger sources
      logic [4:0] len;        // Conversion length
      acc_wr    = 1'b0;
      acc_rd    = 1'b0;
      wd        = pwdata_in[7:0];
      rb        = `ACC_RST_BYTE;
      cmp_evt   = 1'b0;
      cmp_clr   = 1'b0;
      done_set  = 1'b0;
      done_clr  = 1'b0;
      tick      = 1'b0;
      trig_lvl  = 1'b0;
      trig_edge = 1'b0;
      free_run  = 1'b0;
      trig_vec  = {trigger_in, s_reg.cmp_flag, s_reg.done_flag};
      len       = `ACC_TICKS_NORM;
      s_next    = s_reg;

      // Bus access phase: writes and read side effects happen here
      acc_wr = psel_in && penable_in && s_reg.ready && pwrite_in;
      acc_rd = psel_in && penable_in && s_reg.ready && !pwrite_in;

      // Synchronisers for the comparator and the pins
      s_next.cmp_s1   = cmp_raw_in;
      s_next.cmp_s2   = s_reg.cmp_s1;
      s_next.cmp_prev = s_reg.cmp_s2;
      s_next.pin_s1   = pin_raw_in;
      s_next.pin_s2   = s_reg.pin_s1;
      s_next.pin_val  = s_reg.pin_s2 & ~s_reg.did[1:0];

      // Comparator event detection on consecutive samples
      case (s_reg.evt_sel)
         `ACC_EVT_TOGGLE: cmp_evt = s_reg.cmp_s2 ^ s_reg.cmp_prev;
         `ACC_EVT_FALL:   cmp_evt = !s_reg.cmp_s2 && s_reg.cmp_prev;
         `ACC_EVT_RISE:   cmp_evt = s_reg.cmp_s2 && !s_reg.cmp_prev;
         default:         cmp_evt = 1'b0;
      endcase

      // Register writes
      if (acc_wr) begin
         if (paddr_in == `ACC_OFF_CCS) begin
            s_next.cmp_off = wd[`ACC_CCS_OFF];
            s_next.bg_sel  = wd[`ACC_CCS_BG];
            s_next.cmp_ie  = wd[`ACC_CCS_IE];
            s_next.evt_sel = wd[1:0];
            cmp_clr        = wd[`ACC_CCS_FLAG];
         end else if (paddr_in == `ACC_OFF_DID) begin
            s_next.did = wd[5:0];
         end else if (paddr_in == `ACC_OFF_CTLA) begin
            s_next.ena       = wd[`ACC_CTLA_EN];
            s_next.ate       = wd[`ACC_CTLA_ATE];
            s_next.done_ie   = wd[`ACC_CTLA_IE];
            s_next.presc_sel = wd[2:0];
            done_clr         = wd[`ACC_CTLA_FLAG];
            // Writing one together with EN requests a conversion; zero never aborts
            if (wd[`ACC_CTLA_SC] && wd[`ACC_CTLA_EN]) begin
               s_next.start = 1'b1;
            end
         end else if (paddr_in == `ACC_OFF_CTLB) begin
            s_next.mux_en   = wd[`ACC_CTLB_ME];
            s_next.trig_sel = wd[2:0];
         end else if (paddr_in == `ACC_OFF_INSEL) begin
            s_next.insel = wd;
         end
      end

      // Read side effects on the data registers
      if (acc_rd) begin
         if (paddr_in == `ACC_OFF_RESLO) begin
            s_next.lock = 1'b1;
         end else if (paddr_in == `ACC_OFF_RESHI) begin
            s_next.lock = 1'b0;
         end
      end

      // Vector acknowledge also clears the flags
      cmp_clr  = cmp_clr || cmp_vector_ack_in;
      done_clr = done_clr || conv_vector_ack_in;

      // Prescaler, held in reset while the converter is off
      if (!s_reg.ena) begin
         s_next.presc = 8'h00;
      end else if (s_reg.presc == `ACC_PRESC_DIV - 8'h01) begin
         s_next.presc = 8'h00;
         tick         = 1'b1;
      end else begin
         s_next.presc = s_reg.presc + 8'h01;
      end

      // Auto trigger edge detection
      trig_lvl         = trig_vec[s_reg.trig_sel];
      trig_edge        = trig_lvl && !s_reg.trig_prev;
      s_next.trig_prev = trig_lvl;
      free_run = s_reg.ate && (s_reg.trig_sel == `ACC_TRIG_DONE);
      if (s_reg.first) begin
         len = `ACC_TICKS_FIRST;
      end

      // Conversion engine
      case (s_reg.conv)
         ACC_IDLE: begin
            // Selections follow the register only while enabled
            if (s_reg.ena) begin
               s_next.chan   = s_reg.insel[1:0];
               s_next.refsel = s_reg.insel[7:6];
            end
            if (s_reg.ena && s_reg.ate && !free_run && trig_edge
                && !s_reg.start) begin
               // Edge restarts the prescaler and queues a start
               s_next.presc = 8'h00;
               s_next.start = 1'b1;
            end else if (s_reg.ena && s_reg.start && tick) begin
               // Queued start begins on a converter tick
               s_next.conv  = ACC_RUN;
               s_next.ticks = 5'h00;
            end
         end
         ACC_RUN: begin
            // Trigger edges are ignored here; channel is frozen
            if (tick) begin
               if (s_reg.ticks == len - 5'h01) begin
                  done_set     = 1'b1;
                  s_next.first = 1'b0;
                  s_next.ticks = 5'h00;
                  if (!s_reg.lock) begin
                     s_next.result = conv_result_in;
                  end
                  // New selection applies between conversions
                  s_next.chan   = s_reg.insel[1:0];
                  s_next.refsel = s_reg.insel[7:6];
                  if (free_run) begin
                     s_next.start = 1'b1;
                  end else begin
                     s_next.conv  = ACC_IDLE;
                     s_next.start = 1'b0;
                  end
               end else begin
                  s_next.ticks = s_reg.ticks + 5'h01;
               end
            end
         end
         default: begin
            s_next.conv = ACC_IDLE;
         end
      endcase

      // Disabling the converter aborts and rearms the long conversion
      if (!s_reg.ena) begin
         s_next.conv  = ACC_IDLE;
         s_next.start = 1'b0;
         s_next.first = 1'b1;
         s_next.ticks = 5'h00;
      end

      // Flags: a set wins over a clear in the same cycle
      s_next.done_flag = (s_reg.done_flag && !done_clr)
                         || done_set;
      s_next.cmp_flag  = (s_reg.cmp_flag && !cmp_clr)
                         || cmp_evt;

      // Interrupt requests need flag, enable and global enable
      s_next.cmp_irq  = s_next.cmp_flag && s_next.cmp_ie
                        && gie_in;
      s_next.conv_irq = s_next.done_flag && s_next.done_ie && gie_in;

      // Comparator negative input comes from the mux when mux enabled and converter off
      s_next.neg_mux = s_next.mux_en && !s_next.ena;

      // Read data decode, captured in the setup phase
      if (paddr_in == `ACC_OFF_CCS) begin
         rb = {s_reg.cmp_off, s_reg.bg_sel, s_reg.cmp_s2,
               s_reg.cmp_flag, s_reg.cmp_ie, 1'b0,
               s_reg.evt_sel};
      end else if (paddr_in == `ACC_OFF_DID) begin
         rb = {2'h0, s_reg.did};
      end else if (paddr_in == `ACC_OFF_CTLA) begin
         rb = {s_reg.ena, s_reg.start, s_reg.ate,
               s_reg.done_flag, s_reg.done_ie, s_reg.presc_sel};
      end else if (paddr_in == `ACC_OFF_CTLB) begin
         rb = {1'b0, s_reg.mux_en, 3'h0, s_reg.trig_sel};
      end else if (paddr_in == `ACC_OFF_INSEL) begin
         rb = s_reg.insel;
      end else if (paddr_in == `ACC_OFF_RESLO) begin
         if (s_reg.insel[`ACC_INSEL_LAR]) begin
            rb = {s_reg.result[1:0], 6'h00};
         end else begin
            rb = s_reg.result[7:0];
         end
      end else if (paddr_in == `ACC_OFF_RESHI) begin
         if (s_reg.insel[`ACC_INSEL_LAR]) begin
            rb = s_reg.result[9:2];
         end else begin
            rb = {6'h00, s_reg.result[9:8]};
         end
      end else if (paddr_in == `ACC_OFF_PINS) begin
         rb = {6'h00, s_reg.pin_val};
      end

      // Bus handshake: ready one cycle after setup
      s_next.ready = psel_in && !penable_in;
      if (psel_in && !penable_in) begin
         s_next.rdata = {24'h000000, rb};
         s_next.err   = (paddr_in > `ACC_OFF_PINS)
                        || (paddr_in[1:0] != 2'h0);
      end else begin
         s_next.err = s_reg.err && psel_in && !s_reg.ready;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Synchronous reset to documented values
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s_reg           <= '0;
         s_reg.conv      <= ACC_IDLE;
         s_reg.first     <= 1'b1;
         s_reg.did       <= `ACC_RST_DID;
         s_reg.insel     <= `ACC_RST_BYTE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, each straight from the state register
   // ----------------------------------------------------------------------
   assign prdata_out           = s_reg.rdata;
   assign pready_out           = s_reg.ready;
   assign pslverr_out          = s_reg.err;
   assign cmp_irq_out          = s_reg.cmp_irq;
   assign conv_irq_out         = s_reg.conv_irq;
   assign cmp_power_off_out    = s_reg.cmp_off;
   assign cmp_bandgap_sel_out  = s_reg.bg_sel;
   assign cmp_neg_from_mux_out = s_reg.neg_mux;
   assign cmp_mux_channel_out  = s_reg.insel[1:0];
   assign conv_power_out       = s_reg.ena;
   assign conv_busy_out        = s_reg.conv[1];
   assign conv_first_out       = s_reg.first;
   assign conv_channel_out     = s_reg.chan;
   assign conv_reference_out   = s_reg.refsel;
   assign pin_buffer_off_out   = s_reg.did[1:0];
   assign pin_value_out        = s_reg.pin_val;

endmodule : acc_ctrl

/* dv/acc_analog_model.sv */
// Behavioural comparator and converter core facing the control block
`timescale 1ns/1ps
module acc_analog_model (
   // Clock and commanded analog level
   input  wire logic       ref_clk_in,
   input  wire logic       level_in,
   // Controls from the block
   input  wire logic       power_off_in,
   input  wire logic       busy_in,
   input  wire logic [1:0] channel_in,
   // Analog side results
   output logic            cmp_raw_out,
   output logic      [9:0] result_out
);
   logic [5:0] cnt; // Cycles into the running conversion
   // An unpowered comparator sits low
   assign cmp_raw_out = level_in & ~power_off_in;
   // Sample and hold partway in, so a late channel change shows
   always_ff @(posedge ref_clk_in) begin
      cnt <= busy_in ? cnt + 6'h01 : 6'h00;
      if (cnt == 6'd30) begin
         result_out <= {channel_in, 8'ha5};
      end
   end
endmodule : acc_analog_model

/* dv/acc_ctrl_sva.sv */
// Port checker for the converter and comparator control block
`timescale 1ns/1ps
module acc_ctrl_sva (
   // Clock, reset and bus
   input wire logic        ref_clk_in,
   input wire logic        reset_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Interrupts
   input wire logic        gie_in,
   input wire logic        cmp_irq_out,
   input wire logic        conv_irq_out,
   // Comparator, converter and pins
   input wire logic        cmp_power_off_out,
   input wire logic        cmp_bandgap_sel_out,
   input wire logic        cmp_neg_from_mux_out,
   input wire logic        conv_power_out,
   input wire logic        conv_busy_out,
   input wire logic        conv_first_out,
   input wire logic [1:0]  pin_buffer_off_out,
   input wire logic [1:0]  pin_value_out
);
   logic [7:0] busy_cnt; // Cycles the conversion has run
   logic       long_q;   // Running conversion is the long one
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // Count busy cycles, note the kind of conversion at its start
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !conv_busy_out) begin
         busy_cnt <= 8'h00;
      end else if (busy_cnt != 8'hff) begin
         busy_cnt <= busy_cnt + 8'h01;
      end
      if (busy_cnt == 8'h00) begin
         long_q <= conv_first_out;
      end
   end
   a_mux_conv_on: assert property (
      conv_power_out && $past(conv_power_out) |-> !cmp_neg_from_mux_out)
      else $error("comparator fed from mux while converter on");
   a_ccs_copy: assert property (
      psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00
      |=> {cmp_power_off_out, cmp_bandgap_sel_out} == $past(pwdata_in[7:6]))
      else $error("comparator power or bandgap not as written");
   a_irq_gated: assert property (
      cmp_irq_out || conv_irq_out |-> $past(gie_in))
      else $error("interrupt raised without global enable");
   a_conv_length: assert property (
      $fell(conv_busy_out) && conv_power_out |-> (long_q ?
      (busy_cnt >= 8'd99 && busy_cnt <= 8'd101) :
      (busy_cnt >= 8'd51 && busy_cnt <= 8'd53)))
      else $error("conversion length wrong");
   a_idle_off: assert property (
      !conv_power_out && !$past(conv_power_out) |-> !conv_busy_out)
      else $error("conversion runs while converter off");
   a_pin_masked: assert property (
      (pin_buffer_off_out & $past(pin_buffer_off_out) & pin_value_out)
      == 2'b00)
      else $error("disabled pin reads one");
   a_ready_access: assert property (
      psel_in && !penable_in ##1 psel_in && penable_in |-> pready_out)
      else $error("no ready in first access cycle");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready held two cycles");
   a_err_addr: assert property (
      pready_out && (paddr_in > 8'h1c || paddr_in[1:0] != 2'b00)
      |-> pslverr_out)
      else $error("bad address not refused");
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
endmodule : acc_ctrl_sva

bind acc_ctrl acc_ctrl_sva i_acc_ctrl_sva (
   .ref_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .pwdata_in, .pready_out, .pslverr_out, .gie_in, .cmp_irq_out,
   .conv_irq_out, .cmp_power_off_out, .cmp_bandgap_sel_out,
   .cmp_neg_from_mux_out, .conv_power_out, .conv_busy_out,
   .conv_first_out, .pin_buffer_off_out, .pin_value_out);

/* dv/testbench.sv */
// Self-checking bench for the converter and comparator control block
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
   logic        pwrite = 1'b0, gie = 1'b0, cack = 1'b0, level = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [5:0]  trig = 6'h00;
   logic [1:0]  pin = 2'b00, poff, pval, mch, ch, refo;
   logic        pready, pslverr, irq, raw, off, nmux, pwr, busy, e, cirq;
   logic [9:0]  result;
   logic [7:0]  q;
   int          fail_count = 0, samples_checked = 0;
   localparam logic [3:0] RISE = 4'b1001, FALL = 4'b0101;
   typedef struct packed {
      logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;
   } acc_row_s;
   acc_row_s rows [9] = '{'{0,8'h00,8'h00,8'h00,0}, '{0,8'h04,8'h00,8'h00,0},
      '{0,8'h08,8'h00,8'h00,0}, '{1,8'h00,8'hcb,8'hcb,0},
      '{1,8'h04,8'hff,8'h3f,0}, '{1,8'h00,8'h00,8'h00,0},
      '{1,8'h04,8'h00,8'h00,0}, '{1,8'h20,8'hff,8'h00,1},
      '{0,8'h02,8'h00,8'h00,1}};
   always #5 clk = ~clk;
   acc_ctrl i_acc_ctrl (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .gie_in(gie), .cmp_vector_ack_in(cack),
      .conv_vector_ack_in(1'b0), .cmp_irq_out(irq), .conv_irq_out(cirq),
      .trigger_in(trig), .cmp_raw_in(raw), .cmp_power_off_out(off),
      .cmp_bandgap_sel_out(), .cmp_neg_from_mux_out(nmux),
      .cmp_mux_channel_out(mch), .conv_result_in(result),
      .conv_power_out(pwr), .conv_busy_out(busy), .conv_first_out(),
      .conv_channel_out(ch), .conv_reference_out(refo), .pin_raw_in(pin),
      .pin_buffer_off_out(poff), .pin_value_out(pval));
   acc_analog_model i_acc_analog_model (.ref_clk_in(clk), .level_in(level),
      .power_off_in(off), .busy_in(busy), .channel_in(ch),
      .cmp_raw_out(raw), .result_out(result));
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      // Look at ready mid-cycle, finish the transfer at the next edge
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata[7:0];
      e = pslverr;
      @(posedge clk);
      if (n >= 20) fail_count++;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, exp);
      apb(1'b0, a, 8'h00);
      check(q, exp);
   endtask : rd
   // Wait for a conversion to start and finish, bounded
   task automatic conv_wait();
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      while (busy !== 1'b0 && n < 140) begin
         @(posedge clk);
         n++;
      end
      if (n >= 140) fail_count++;
   endtask : conv_wait
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      #300000;
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].q);
         check(8'(e), 8'(rows[i].e));
      end
      // Every event select against a rise and a fall
      for (int s = 0; s < 4; s++) begin
         wr(8'h00, {6'h04, s[1:0]});
         level <= 1'b1;
         repeat (8) @(posedge clk);
         rd(8'h00, {3'b001, RISE[s], 2'b00, s[1:0]});
         wr(8'h00, {6'h04, s[1:0]});
         level <= 1'b0;
         repeat (8) @(posedge clk);
         rd(8'h00, {3'b000, FALL[s], 2'b00, s[1:0]});
      end
      wr(8'h00, 8'h1b);
      gie <= 1'b1;
      level <= 1'b1;
      repeat (8) @(posedge clk);
      check(8'(irq), 8'h01);
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      check(8'(irq), 8'h00);
      gie <= 1'b1;
      cack <= 1'b1;
      @(posedge clk);
      cack <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h00, 8'h2b);
      pin <= 2'b11;
      wr(8'h04, 8'h01);
      repeat (4) @(posedge clk);
      check({4'h0, poff, pval}, 8'h06);
      wr(8'h0c, 8'h40);
      wr(8'h10, 8'h03);
      repeat (2) @(posedge clk);
      check({5'h00, nmux, mch}, 8'h07);
      // Software conversions, adjust, lock and channel change
      wr(8'h08, 8'h80);
      wr(8'h10, 8'h02);
      wr(8'h08, 8'hc0);
      rd(8'h08, 8'hc0);
      conv_wait();
      rd(8'h08, 8'h90);
      rd(8'h14, 8'ha5);
      rd(8'h18, 8'h02);
      wr(8'h10, 8'h22);
      rd(8'h14, 8'h40);
      rd(8'h18, 8'ha9);
      wr(8'h10, 8'h01);
      rd(8'h14, 8'ha5);
      wr(8'h08, 8'hd0);
      conv_wait();
      rd(8'h08, 8'h90);
      rd(8'h18, 8'h02);
      wr(8'h08, 8'hd0);
      repeat (8) @(posedge clk);
      wr(8'h10, 8'h03);
      conv_wait();
      rd(8'h14, 8'ha5);
      rd(8'h18, 8'h01);
      // Auto trigger with a held and a repeated edge
      wr(8'h0c, 8'h02);
      wr(8'h08, 8'hb0);
      trig <= 6'h01;
      repeat (8) @(posedge clk);
      rd(8'h08, 8'he0);
      trig <= 6'h00;
      @(posedge clk);
      trig <= 6'h01;
      conv_wait();
      repeat (30) @(posedge clk);
      check(8'(busy), 8'h00);
      // Free running needs a software start, then keeps going
      wr(8'h0c, 8'h00);
      wr(8'h08, 8'hb0);
      repeat (30) @(posedge clk);
      check(8'(busy), 8'h00);
      wr(8'h10, 8'hc1);
      wr(8'h08, 8'he8);
      repeat (120) @(posedge clk);
      rd(8'h08, 8'hf8);
      check({6'h00, refo}, 8'h03);
      check(8'(cirq), 8'h01);
      wr(8'h08, 8'h00);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
      print_verdict();
   end
endmodule : testbench
